// [hdl/mtc_pkg.sv]
// Purpose: Shared constants of the modulator transmit control block.
// Assumes: Classic Wishbone register access, 32-bit data, byte addresses.
// Notes: Format and carrier encodings are used by the control logic only; the limit logic takes the decoded frame type and code rate.
// How it works
// (R1) Output forced off while general alarm active.
// (R2) General alarm ORs four alarm sources.
// (R3) Transmit returns after alarm clears if enabled.
// (R4) Signal-altering setting change clears transmit enable.
// (R5) Operator re-enables transmit after inspecting signal.
// (R6) Transmit state saved in boot slot zero.
// (R7) Gain control: fixed manual or feedback loop.
// (R8) Constant-power level plan is the default.
// (R9) Constant-rim plan only under manual gain.
// (R10) Rim plan: 16APSK +1 dB, QPSK/8PSK +2 dB.
// (R11) Send-timing clock tracks rate or manual value.
// (R12) Internal clock: stuff if faster, else incompatible; equal rates raise neither.
// (R13) Carrier: pure, normal, rotating baud/4, /8, /16.
// (R14) Separate L-band, RF and external path enables.
// (R15) Maximum field length from frame type, modcod.
// (R16) Auto mode: field length max, sync zero.
// (R17) Manual mode keeps field length when supported.
// (R18) Manual mode clips field length to maximum.
// (R19) Manual mode keeps or clips sync distance.
// (R20) Field length applies only to non-frame inputs.
// (R21) Effective output is enable and not alarm.
package mtc_pkg;
  localparam int MTC_RATE_W = 32;
  localparam int MTC_DFL_W = 16;
  localparam int MTC_NUM_SIG = 4;
  // Register byte offsets.
  localparam logic [7:0] MTC_CTRL_OFF = 8'h00;
  localparam logic [7:0] MTC_STFREQ_OFF = 8'h04;
  localparam logic [7:0] MTC_IFRATE_OFF = 8'h08;
  localparam logic [7:0] MTC_SYMRATE_OFF = 8'h0C;
  localparam logic [7:0] MTC_FORMAT_OFF = 8'h10;
  localparam logic [7:0] MTC_OUTFREQ_OFF = 8'h14;
  localparam logic [7:0] MTC_STATUS_OFF = 8'h18;
  localparam logic [7:0] MTC_DFL_OFF = 8'h1C;
  localparam logic [7:0] MTC_SYNCD_OFF = 8'h20;
  // Control register fields.
  localparam int MTC_CTRL_TX = 0;
  localparam int MTC_CTRL_AGC = 1;
  localparam int MTC_CTRL_RIM = 2;
  localparam int MTC_CTRL_STMAN = 3;
  localparam int MTC_CTRL_CAR_LO = 4;
  localparam int MTC_CTRL_LBAND = 7;
  localparam int MTC_CTRL_RFOUT = 8;
  localparam int MTC_CTRL_EXTIN = 9;
  localparam int MTC_CTRL_DFLMAN = 10;
  localparam int MTC_CTRL_SAVE = 11;
  localparam int MTC_CTRL_INTCLK = 12;
  localparam int MTC_CTRL_BBIN = 13;
  localparam logic [31:0] MTC_CTRL_RST = 32'h0000_0012;
  // Format register fields.
  localparam int MTC_FMT_RATE_LO = 0;
  localparam int MTC_FMT_MOD_LO = 4;
  localparam int MTC_FMT_SHORT = 7;
  localparam logic [31:0] MTC_FMT_DFL_MASK = 32'h0000_00FF;
  localparam logic [31:0] MTC_FORMAT_RST = 32'h0000_1086;
  localparam logic [15:0] MTC_DFL_RST = 16'h05AE;
  // Modulation codes.
  localparam logic [2:0] MTC_MOD_QPSK = 3'h0;
  localparam logic [2:0] MTC_MOD_8PSK = 3'h1;
  localparam logic [2:0] MTC_MOD_16APSK = 3'h2;
  localparam logic [2:0] MTC_MOD_32APSK = 3'h3;
  // Carrier modes and level boosts in dB.
  localparam logic [2:0] MTC_CAR_PURE = 3'h0;
  localparam logic [2:0] MTC_CAR_ON = 3'h1;
  localparam logic [2:0] MTC_CAR_DIV8 = 3'h2;
  localparam logic [2:0] MTC_CAR_DIV4 = 3'h3;
  localparam logic [2:0] MTC_CAR_DIV16 = 3'h4;
  localparam logic [1:0] MTC_BOOST_16APSK = 2'h1;
  localparam logic [1:0] MTC_BOOST_PSK = 2'h2;
  typedef enum logic [1:0] {MTC_ST_IDLE = 2'b01, MTC_ST_APPLY = 2'b10} mtc_dfl_state_e;
endpackage

// [hdl/mtc_dfl_limit.sv]
// Purpose: Largest data field length for a frame type and code rate.
// Assumes: Code rate index 0..10 is 1/4,1/3,2/5,1/2,3/5,2/3,3/4,4/5,5/6,8/9,9/10.
// Notes: Payload is the BCH block less the 80-bit header, in bytes; zero means unsupported.
`timescale 1ns/100ps
module mtc_dfl_limit import mtc_pkg::*; (
  // Selection
  input wire logic frame_short,
  input wire logic [3:0] code_rate,
  // Result
  output logic [MTC_DFL_W-1:0] max_dfl
);
  always_comb begin
    max_dfl = 16'h0000;
    case ({frame_short, code_rate}) // [R15]
      5'h00: max_dfl = 16'h07C7;
      5'h01: max_dfl = 16'h0A6A;
      5'h02: max_dfl = 16'h0C86;
      5'h03: max_dfl = 16'h0FB0;
      5'h04: max_dfl = 16'h12DA;
      5'h05: max_dfl = 16'h14FA;
      5'h06: max_dfl = 16'h1799;
      5'h07: max_dfl = 16'h192E;
      5'h08: max_dfl = 16'h1A40;
      5'h09: max_dfl = 16'h1C06;
      5'h0A: max_dfl = 16'h1C60;
      5'h10: max_dfl = 16'h0176;
      5'h11: max_dfl = 16'h0284;
      5'h12: max_dfl = 16'h030B;
      5'h13: max_dfl = 16'h0365;
      5'h14: max_dfl = 16'h04A0;
      5'h15: max_dfl = 16'h0527;
      5'h16: max_dfl = 16'h05AE;
      5'h17: max_dfl = 16'h0608;
      5'h18: max_dfl = 16'h0662;
      5'h19: max_dfl = 16'h06E9;
      default: max_dfl = 16'h0000;
    endcase
  end
endmodule // mtc_dfl_limit

// [hdl/mtc_tx_control.sv]
// Purpose: Transmit gating, level plan, send timing, carrier mode and field length control.
// Assumes: All inputs synchronous to mclk; classic Wishbone slave with one wait state.
// Notes: The boot slot itself lives outside; this block reads and writes it over plain pins.
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
module mtc_tx_control import mtc_pkg::*; #(
  parameter int RATE_W = MTC_RATE_W,
  parameter int DFL_W = MTC_DFL_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Alarm sources
  input wire logic incompat_alarm,
  input wire logic ref10_alarm,
  input wire logic ref_pll_alarm,
  input wire logic synth_lock_alarm,
  // Timing
  input wire logic st_clock_in_use,
  input wire logic symbol_strobe,
  // Boot slot zero
  input wire logic boot_tx_state,
  output logic boot_save_strobe,
  output logic boot_save_value,
  // Output path control
  output logic tx_output_on,
  output logic internal_lband_tx_enable,
  output logic rf_output_enable,
  output logic external_lband_path_enable,
  output logic agc_enable,
  output logic [1:0] level_boost_db,
  // Send timing
  output logic [RATE_W-1:0] send_timing_frequency,
  output logic null_insert,
  // Carrier
  output logic carrier_unmodulated,
  output logic [3:0] rotate_phase,
  // Framing
  output logic [DFL_W-1:0] applied_dfl,
  output logic [DFL_W-1:0] sync_distance
);
  if (RATE_W < 8 || RATE_W > 32) begin : g_rate_chk
    $error("RATE_W must lie between 8 and 32.");
  end
  if (DFL_W != MTC_DFL_W) begin : g_dfl_chk
    $error("DFL_W must match the field length table width.");
  end

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [DFL_W-1:0] clip(input logic [DFL_W-1:0] v, input logic [DFL_W-1:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  // Bus handshake: ack follows the request by one cycle and writes commit on the ack edge.
  logic [31:0] ctrl;
  logic tx_enable;
  logic [31:0] st_manual;
  logic [31:0] sig_reg [MTC_NUM_SIG];
  logic [DFL_W-1:0] dfl;
  logic [DFL_W-1:0] syncd;
  logic boot_pending;
  logic dfl_pending;
  mtc_dfl_state_e dfl_state;
  mtc_dfl_state_e next_dfl_state;

  wire bus_req = wb_cyc_i & wb_stb_i;
  wire wr_commit = bus_req & wb_we_i & wb_ack_o;
  wire hit_ctrl = (wb_adr_i == MTC_CTRL_OFF);
  wire hit_st = (wb_adr_i == MTC_STFREQ_OFF);
  wire hit_status = (wb_adr_i == MTC_STATUS_OFF);
  wire hit_dfl = (wb_adr_i == MTC_DFL_OFF);
  wire hit_syncd = (wb_adr_i == MTC_SYNCD_OFF);
  wire [7:0] sig_off [MTC_NUM_SIG];
  assign sig_off[0] = MTC_IFRATE_OFF;
  assign sig_off[1] = MTC_SYMRATE_OFF;
  assign sig_off[2] = MTC_FORMAT_OFF;
  assign sig_off[3] = MTC_OUTFREQ_OFF;

  // Signal-altering registers: interface rate, symbol rate, format, output frequency.
  logic [MTC_NUM_SIG-1:0] sig_hit;
  logic [MTC_NUM_SIG-1:0] sig_changed;
  logic [31:0] sig_next [MTC_NUM_SIG];
  genvar gi;
  for (gi = 0; gi < MTC_NUM_SIG; gi++) begin : g_sig
    assign sig_hit[gi] = (wb_adr_i == sig_off[gi]);
    assign sig_next[gi] = merge_bytes(sig_reg[gi], wb_dat_i, wb_sel_i);
    assign sig_changed[gi] = wr_commit & sig_hit[gi] & (sig_next[gi] != sig_reg[gi]);
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        sig_reg[gi] <= (gi == 2) ? MTC_FORMAT_RST : 32'h0000_0000;
      end else if (wr_commit && sig_hit[gi]) begin
        sig_reg[gi] <= sig_next[gi];
      end
    end
  end
  wire any_sig_change = |sig_changed;
  wire fmt_dfl_change = sig_changed[2] & |((sig_next[2] ^ sig_reg[2]) & MTC_FMT_DFL_MASK);

  // Field decode of the stored settings.
  wire [31:0] ctrl_next = merge_bytes(ctrl, wb_dat_i, wb_sel_i);
  wire gain_control_mode_select = ctrl[MTC_CTRL_AGC];
  wire output_level_plan_select = ctrl[MTC_CTRL_RIM];
  wire send_timing_mode_select = ctrl[MTC_CTRL_STMAN];
  wire [2:0] carrier_mode_select = ctrl[MTC_CTRL_CAR_LO +: 3];
  wire field_length_mode_select = ctrl[MTC_CTRL_DFLMAN];
  wire [3:0] code_rate = sig_reg[2][MTC_FMT_RATE_LO +: 4];
  wire [2:0] modulation = sig_reg[2][MTC_FMT_MOD_LO +: 3];
  wire frame_short = sig_reg[2][MTC_FMT_SHORT];
  wire [RATE_W-1:0] if_rate = sig_reg[0][RATE_W-1:0];

  // Alarm and transmit gating.
  logic st_incompat;
  wire incompat_all = incompat_alarm | st_incompat;
  wire general_alarm = incompat_all | ref10_alarm | ref_pll_alarm | synth_lock_alarm; // [R2]

  // The stored enable is cleared by setting changes, never by the alarm, so transmit resumes
  // by itself once the alarm clears.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_enable <= 1'b0;
    end else if (boot_pending) begin
      tx_enable <= boot_tx_state; // [R6]
    end else if (any_sig_change) begin
      tx_enable <= 1'b0; // [R4]
    end else if (wr_commit && hit_ctrl && wb_sel_i[0]) begin
      tx_enable <= wb_dat_i[MTC_CTRL_TX]; // [R5]
    end
  end

  // The boot slot level is read once, in the first cycle after reset release.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      boot_pending <= 1'b1;
    end else begin
      boot_pending <= 1'b0;
    end
  end

  // The saved level is the enable as it stood before the writing cycle, so a write that sets the
  // save bit and bit 0 together saves the old state; software sets the enable first.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      boot_save_strobe <= 1'b0;
      boot_save_value <= 1'b0;
    end else begin
      boot_save_strobe <= wr_commit & hit_ctrl & wb_sel_i[1] & wb_dat_i[MTC_CTRL_SAVE]; // [R6]
      if (wr_commit && hit_ctrl && wb_sel_i[1] && wb_dat_i[MTC_CTRL_SAVE]) begin
        boot_save_value <= tx_enable;
      end
    end
  end

  // Control word: the save bit is a strobe and the rim plan is refused under AGC.
  wire [31:0] ctrl_store = {ctrl_next[31:MTC_CTRL_SAVE+1], 1'b0, ctrl_next[MTC_CTRL_SAVE-1:MTC_CTRL_RIM+1],
                            ctrl_next[MTC_CTRL_RIM] & ~ctrl_next[MTC_CTRL_AGC], // [R9]
                            ctrl_next[MTC_CTRL_AGC:0]};
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= MTC_CTRL_RST; // [R8]
    end else if (wr_commit && hit_ctrl) begin
      ctrl <= ctrl_store;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_manual <= 32'h0000_0000;
    end else if (wr_commit && hit_st) begin
      st_manual <= merge_bytes(st_manual, wb_dat_i, wb_sel_i);
    end
  end

  // Send timing frequency and the internal clock comparison.
  wire [RATE_W-1:0] st_freq = send_timing_mode_select ? st_manual[RATE_W-1:0] : if_rate; // [R11]
  // Equal rates need neither stuffing nor an alarm.
  wire st_compare = ctrl[MTC_CTRL_INTCLK] & st_clock_in_use;
  wire next_null = st_compare & (if_rate > st_freq); // [R12]
  wire next_st_incompat = st_compare & (if_rate < st_freq); // [R12]

  // Constant-rim boost relative to the 32APSK reference.
  logic [1:0] next_boost;
  assign next_boost = !output_level_plan_select ? 2'h0 :
                      (modulation == MTC_MOD_16APSK) ? MTC_BOOST_16APSK :
                      (modulation == MTC_MOD_QPSK || modulation == MTC_MOD_8PSK) ? MTC_BOOST_PSK :
                      2'h0; // [R10]

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      send_timing_frequency <= '0;
      null_insert <= 1'b0;
      st_incompat <= 1'b0;
      level_boost_db <= 2'h0;
      agc_enable <= 1'b0;
    end else begin
      send_timing_frequency <= st_freq; // [R11]
      null_insert <= next_null;
      st_incompat <= next_st_incompat;
      level_boost_db <= next_boost; // [R10]
      agc_enable <= gain_control_mode_select; // [R7]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_output_on <= 1'b0;
      internal_lband_tx_enable <= 1'b0;
      rf_output_enable <= 1'b0;
      external_lband_path_enable <= 1'b0;
    end else begin
      tx_output_on <= tx_enable & ~general_alarm; // [R1] [R3] [R21]
      internal_lband_tx_enable <= ctrl[MTC_CTRL_LBAND]; // [R14]
      rf_output_enable <= ctrl[MTC_CTRL_RFOUT]; // [R14]
      external_lband_path_enable <= ctrl[MTC_CTRL_EXTIN]; // [R14]
    end
  end

  // Carrier test rotation: a 16-step phase advanced per symbol by 16/n.
  logic [3:0] phase_step;
  assign phase_step = (carrier_mode_select == MTC_CAR_DIV4) ? 4'h4 :
                      (carrier_mode_select == MTC_CAR_DIV8) ? 4'h2 :
                      (carrier_mode_select == MTC_CAR_DIV16) ? 4'h1 : 4'h0; // [R13]
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rotate_phase <= 4'h0;
      carrier_unmodulated <= 1'b0;
    end else begin
      carrier_unmodulated <= (carrier_mode_select == MTC_CAR_PURE); // [R13]
      if (phase_step == 4'h0) begin
        rotate_phase <= 4'h0;
      end else if (symbol_strobe) begin
        rotate_phase <= rotate_phase + phase_step; // [R13]
      end
    end
  end

  // Field length handling. The new limit reaches the field length register two cycles after the format write.
  logic [DFL_W-1:0] max_dfl;
  mtc_dfl_limit u_limit (
    .frame_short(frame_short),
    .code_rate(code_rate),
    .max_dfl(max_dfl)
  );

  always_comb begin
    next_dfl_state = dfl_state;
    case (dfl_state)
      MTC_ST_IDLE: begin
        if (dfl_pending) begin
          next_dfl_state = MTC_ST_APPLY;
        end
      end
      MTC_ST_APPLY: next_dfl_state = MTC_ST_IDLE;
      default: next_dfl_state = MTC_ST_IDLE;
    endcase
  end

  // The apply cycle outranks the bus, so a length write committed in it would be lost. With one
  // wait state and an idle cycle between requests, the earliest next commit comes one edge later.
  wire [DFL_W-1:0] man_dfl = clip(dfl, max_dfl); // [R17] [R18]
  wire [31:0] dfl_wr = merge_bytes({16'h0000, dfl}, wb_dat_i, wb_sel_i);
  wire [31:0] syncd_wr = merge_bytes({16'h0000, syncd}, wb_dat_i, wb_sel_i);
  wire [DFL_W-1:0] dfl_wr_clip = clip(dfl_wr[DFL_W-1:0], max_dfl);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dfl_state <= MTC_ST_IDLE;
      dfl_pending <= 1'b0;
      dfl <= MTC_DFL_RST;
      syncd <= '0;
    end else begin
      dfl_state <= next_dfl_state;
      dfl_pending <= fmt_dfl_change; // [R16]
      if (dfl_state == MTC_ST_APPLY) begin
        if (!field_length_mode_select) begin
          dfl <= max_dfl; // [R16]
          syncd <= '0; // [R16]
        end else begin
          dfl <= man_dfl; // [R17] [R18]
          syncd <= clip(syncd, man_dfl); // [R19]
        end
      end else if (wr_commit && hit_dfl) begin
        dfl <= dfl_wr_clip; // [R15]
        syncd <= clip(syncd, dfl_wr_clip);
      end else if (wr_commit && hit_syncd) begin
        syncd <= clip(syncd_wr[DFL_W-1:0], dfl);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      applied_dfl <= '0;
      sync_distance <= '0;
    end else begin
      applied_dfl <= ctrl[MTC_CTRL_BBIN] ? '0 : dfl; // [R20]
      sync_distance <= ctrl[MTC_CTRL_BBIN] ? '0 : syncd; // [R20]
    end
  end

  // Read path. Unmapped addresses read zero and writes to them are dropped, but still acked.
  // A master that holds its strobe past ack sees a fresh ack every other cycle.
  wire [31:0] status_word = {23'h000000, tx_enable, st_incompat, null_insert, tx_output_on,
                             general_alarm, synth_lock_alarm, ref_pll_alarm, ref10_alarm, incompat_all};
  wire [31:0] ctrl_word = {ctrl[31:1], tx_enable};
  wire [31:0] sig_rd = sig_hit[0] ? sig_reg[0] : sig_hit[1] ? sig_reg[1] :
                       sig_hit[2] ? sig_reg[2] : sig_hit[3] ? sig_reg[3] : 32'h0000_0000;
  wire [31:0] rd_word = hit_ctrl ? ctrl_word :
                        hit_st ? st_manual :
                        hit_status ? status_word :
                        hit_dfl ? {16'h0000, dfl} :
                        hit_syncd ? {16'h0000, syncd} : sig_rd;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req && !wb_ack_o && !wb_we_i) begin
        wb_dat_o <= rd_word;
      end
    end
  end
endmodule // mtc_tx_control

// [dv/mtc_tx_control_monitor.sv]
// Purpose: Port-level checker for the transmit control block.
// Assumes: One clock domain; reset is active low.
// Notes: Bound onto every instance of the block.
`timescale 1ns/100ps
module mtc_tx_control_monitor import mtc_pkg::*; #(
  parameter int RATE_W = MTC_RATE_W,
  parameter int DFL_W = MTC_DFL_W
) (
  // Clock, reset and bus
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Alarms and timing
  input wire logic incompat_alarm,
  input wire logic ref10_alarm,
  input wire logic ref_pll_alarm,
  input wire logic synth_lock_alarm,
  input wire logic st_clock_in_use,
  input wire logic symbol_strobe,
  // Outputs under watch
  input wire logic boot_save_strobe,
  input wire logic tx_output_on,
  input wire logic agc_enable,
  input wire logic [1:0] level_boost_db,
  input wire logic null_insert,
  input wire logic carrier_unmodulated,
  input wire logic [3:0] rotate_phase,
  input wire logic [DFL_W-1:0] applied_dfl,
  input wire logic [DFL_W-1:0] sync_distance
);
  logic any_alarm;
  assign any_alarm = incompat_alarm | ref10_alarm | ref_pll_alarm | synth_lock_alarm;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_ack_one; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  property p_alarm_off; any_alarm |=> !tx_output_on; endproperty
  property p_out_rise; $rose(tx_output_on) |-> !$past(any_alarm); endproperty
  property p_boot_pulse; $rose(boot_save_strobe) |=> !boot_save_strobe; endproperty
  property p_rim_mgc; level_boost_db != 2'h0 |-> !agc_enable; endproperty
  property p_boost_set; level_boost_db inside {2'h0, 2'h1, 2'h2}; endproperty
  property p_null_cause; null_insert |-> $past(st_clock_in_use); endproperty
  property p_rot_step;
    $changed(rotate_phase) && rotate_phase != 4'h0 |->
      $past(symbol_strobe) && (4'(rotate_phase - $past(rotate_phase)) inside {4'h1, 4'h2, 4'h4});
  endproperty
  property p_pure_still; carrier_unmodulated |-> rotate_phase == 4'h0; endproperty
  property p_sync_le; sync_distance <= applied_dfl; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not one pulse one cycle after request");
  a_alarm_off: assert property (p_alarm_off) else $error("output on during alarm");
  a_out_rise: assert property (p_out_rise) else $error("output rose while alarmed");
  a_boot_pulse: assert property (p_boot_pulse) else $error("boot save strobe too long");
  a_rim_mgc: assert property (p_rim_mgc) else $error("rim boost under automatic gain");
  a_boost_set: assert property (p_boost_set) else $error("level boost out of range");
  a_null_cause: assert property (p_null_cause) else $error("stuffing without send timing");
  a_rot_step: assert property (p_rot_step) else $error("bad rotation step");
  a_pure_still: assert property (p_pure_still) else $error("pure carrier rotating");
  a_sync_le: assert property (p_sync_le) else $error("sync distance above field length");
  c_alarm: cover property (any_alarm ##1 !tx_output_on);
  c_boost: cover property (level_boost_db == 2'h2);
  c_null: cover property (null_insert);
  c_boot: cover property (boot_save_strobe);
endmodule // mtc_tx_control_monitor

bind mtc_tx_control mtc_tx_control_monitor #(.RATE_W(RATE_W), .DFL_W(DFL_W)) u_mon (
  .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .incompat_alarm(incompat_alarm), .ref10_alarm(ref10_alarm), .ref_pll_alarm(ref_pll_alarm),
  .synth_lock_alarm(synth_lock_alarm), .st_clock_in_use(st_clock_in_use), .symbol_strobe(symbol_strobe),
  .boot_save_strobe(boot_save_strobe), .tx_output_on(tx_output_on), .agc_enable(agc_enable),
  .level_boost_db(level_boost_db), .null_insert(null_insert), .carrier_unmodulated(carrier_unmodulated),
  .rotate_phase(rotate_phase), .applied_dfl(applied_dfl), .sync_distance(sync_distance));

// [dv/test_mtc_tx_control.sv]
// Purpose: Self-checking bench for the transmit control block.
// Assumes: Classic Wishbone; stimulus changes on rising edges.
// Notes: Field length figures are short-frame payloads in bytes.
`timescale 1ns/100ps
module test_mtc_tx_control import mtc_pkg::*; ;
  typedef struct packed {logic [31:0] ctrl; logic [31:0] fmt; logic [6:0] exp;} mtc_row_s;
  logic mclk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic st_use = 1'b0, sym = 1'b0, boot = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF, alm = 4'h0, rot;
  logic [31:0] wdat = 32'h0, rd, dat_o, stf;
  logic ack, save_stb, save_val, out_on, lb, rf, ext, agc, nul, unmod;
  logic [1:0] boost;
  logic [15:0] dfl, syncd;
  int failures = 0, tests_run = 0;
  // Rows: control, format, expected {lband, rf, ext, agc, pure, boost}.
  mtc_row_s rows [10] = '{'{32'h12, 32'h1086, 7'h08}, '{32'h90, 32'h1086, 7'h40},
    '{32'h110, 32'h1086, 7'h20}, '{32'h210, 32'h1086, 7'h10}, '{32'h14, 32'h1006, 7'h02},
    '{32'h14, 32'h1016, 7'h02}, '{32'h14, 32'h1026, 7'h01}, '{32'h14, 32'h1036, 7'h00},
    '{32'h16, 32'h1006, 7'h08}, '{32'h00, 32'h1006, 7'h04}};
  logic [39:0] chg [8] = '{40'h08_0000_1000, 40'h0C_0000_2000, 40'h10_0000_1085, 40'h10_0000_1095,
    40'h10_0000_1395, 40'h10_0000_1795, 40'h10_0000_0795, 40'h14_0000_0055};
  logic [7:0] car [3] = '{8'h34, 8'h22, 8'h41};

  mtc_tx_control DUT (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .incompat_alarm(alm[0]), .ref10_alarm(alm[1]), .ref_pll_alarm(alm[2]), .synth_lock_alarm(alm[3]),
    .st_clock_in_use(st_use), .symbol_strobe(sym), .boot_tx_state(boot), .boot_save_strobe(save_stb),
    .boot_save_value(save_val), .tx_output_on(out_on), .internal_lband_tx_enable(lb),
    .rf_output_enable(rf), .external_lband_path_enable(ext), .agc_enable(agc), .level_boost_db(boost),
    .send_timing_frequency(stf), .null_insert(nul), .carrier_unmodulated(unmod), .rotate_phase(rot),
    .applied_dfl(dfl), .sync_distance(syncd));

  initial begin
    forever #4 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The request is held until ack is sampled high, so no wait count is assumed.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) failures++;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    wait_clk(3);
    check(32'(out_on), 32'h1);
    rchk(MTC_CTRL_OFF, MTC_CTRL_RST | 32'h1);
    rchk(MTC_FORMAT_OFF, MTC_FORMAT_RST);
    rchk(MTC_DFL_OFF, 32'(MTC_DFL_RST));
    xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
    rchk(8'h40, 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      alm <= 4'h1 << i;
      wait_clk(2);
      check(32'(out_on), 32'h0);
      rchk(MTC_STATUS_OFF, 32'h110 | (32'h1 << i));
      @(posedge mclk);
      alm <= 4'h0;
      wait_clk(3);
      check(32'(out_on), 32'h1);
    end
    foreach (rows[i]) begin
      xfer(1'b1, MTC_FORMAT_OFF, rows[i].fmt);
      xfer(1'b1, MTC_CTRL_OFF, rows[i].ctrl);
      wait_clk(3);
      check(32'({lb, rf, ext, agc, unmod, boost}), 32'(rows[i].exp));
    end
    foreach (chg[i]) begin
      xfer(1'b1, MTC_CTRL_OFF, 32'h13);
      wait_clk(2);
      check(32'(out_on), 32'h1);
      xfer(1'b1, chg[i][39:32], chg[i][31:0]);
      wait_clk(2);
      check(32'(out_on), 32'h0);
      rchk(MTC_CTRL_OFF, 32'h12);
    end
    xfer(1'b1, MTC_CTRL_OFF, 32'h13);
    xfer(1'b1, MTC_OUTFREQ_OFF, 32'h55);
    rchk(MTC_CTRL_OFF, 32'h13);
    xfer(1'b1, MTC_STFREQ_OFF, 32'h800);
    wait_clk(2);
    check(stf, 32'h1000);
    xfer(1'b1, MTC_CTRL_OFF, 32'h1018);
    @(posedge mclk);
    st_use <= 1'b1;
    wait_clk(3);
    check(stf, 32'h800);
    check(32'(nul), 32'h1);
    xfer(1'b1, MTC_STFREQ_OFF, 32'h2000);
    wait_clk(3);
    check(32'(nul), 32'h0);
    xfer(1'b0, MTC_STATUS_OFF, 32'h0);
    check(rd & 32'h80, 32'h80);
    @(posedge mclk);
    st_use <= 1'b0;
    foreach (car[i]) begin
      xfer(1'b1, MTC_CTRL_OFF, 32'h10);
      xfer(1'b1, MTC_CTRL_OFF, 32'(car[i][7:4]) << MTC_CTRL_CAR_LO);
      repeat (3) begin
        @(posedge mclk);
        sym <= 1'b1;
        @(posedge mclk);
        sym <= 1'b0;
      end
      wait_clk(2);
      check(32'(rot), 32'(car[i][3:0]) * 32'h3);
    end
    xfer(1'b1, MTC_CTRL_OFF, 32'h10);
    xfer(1'b1, MTC_SYNCD_OFF, 32'h10);
    xfer(1'b1, MTC_FORMAT_OFF, 32'h1083);
    wait_clk(4);
    check(32'({dfl, syncd}), 32'h0365_0000);
    xfer(1'b1, MTC_CTRL_OFF, 32'h410);
    xfer(1'b1, MTC_DFL_OFF, 32'h100);
    xfer(1'b1, MTC_SYNCD_OFF, 32'h80);
    xfer(1'b1, MTC_FORMAT_OFF, 32'h1086);
    wait_clk(4);
    check(32'({dfl, syncd}), 32'h0100_0080);
    xfer(1'b1, MTC_DFL_OFF, 32'h300);
    xfer(1'b1, MTC_SYNCD_OFF, 32'h200);
    xfer(1'b1, MTC_FORMAT_OFF, 32'h1080);
    wait_clk(4);
    rchk(MTC_DFL_OFF, 32'h176);
    check(32'(syncd), 32'h176);
    xfer(1'b1, MTC_CTRL_OFF, 32'h2410);
    wait_clk(3);
    check(32'({dfl, syncd}), 32'h0);
    xfer(1'b1, MTC_CTRL_OFF, 32'h11);
    sel <= 4'h2;
    xfer(1'b1, MTC_CTRL_OFF, 32'h800);
    #1;
    check(32'({save_stb, save_val}), 32'h3);
    rchk(MTC_CTRL_OFF, 32'h11);
    @(posedge mclk);
    boot <= 1'b0;
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    wait_clk(3);
    check(32'(out_on), 32'h0);
    rchk(MTC_CTRL_OFF, MTC_CTRL_RST);
    wait_clk(4);
    finish_test();
  end
endmodule // test_mtc_tx_control
